// ===== src/ctl_pkg.sv
`default_nettype none
package ctl_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PC_W = 15;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] SP_RESET = 8'h6F;
  localparam logic [14:0] VEC_BASE = 15'h7E00;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [1:0] OP_REL_TOP = 2'h0;
  localparam logic [3:0] OP_LDB_SHORT_HI = 4'h4;
  localparam logic [3:0] OP_PAGE_JUMP_HI = 4'h5;
  localparam logic [7:0] OP_LONG_JUMP = 8'h60;
  localparam logic [7:0] OP_CALL = 8'h61;
  localparam logic [7:0] OP_RETURN = 8'h62;
  localparam logic [7:0] OP_RETURN_SKIP = 8'h63;
  localparam logic [7:0] OP_INT_RETURN = 8'h64;
  localparam logic [7:0] OP_TABLE_READ = 8'h65;
  localparam logic [7:0] OP_INDIRECT_JUMP = 8'h66;
  localparam logic [7:0] OP_VECTOR_SEL = 8'h67;
  localparam logic [7:0] OP_NOP = 8'h68;
  localparam logic [7:0] OP_ROT_RIGHT = 8'h69;
  localparam logic [7:0] OP_ROT_LEFT = 8'h6A;
  localparam logic [7:0] OP_SWAP_NIB = 8'h6B;
  localparam logic [7:0] OP_ADD = 8'h70;
  localparam logic [7:0] OP_ADD_C = 8'h71;
  localparam logic [7:0] OP_SUB = 8'h72;
  localparam logic [7:0] OP_SUB_C = 8'h73;
  localparam logic [7:0] OP_LDA_IMM = 8'h74;
  localparam logic [7:0] OP_IF_EQ = 8'h75;
  localparam logic [7:0] OP_IF_C = 8'h76;
  localparam logic [7:0] OP_IF_NC = 8'h77;
  localparam logic [7:0] OP_XCH_BINC = 8'h78;
  localparam logic [7:0] OP_XCH_BDEC = 8'h79;
  localparam logic [7:0] OP_XCH_XINC = 8'h7A;
  localparam logic [7:0] OP_XCH_XDEC = 8'h7B;
  localparam logic [7:0] OP_LDX_IMM = 8'h7C;
  localparam logic [7:0] OP_LDB_IMM = 8'h7D;

  typedef enum logic [3:0] {
    S_FETCH = 4'b0000,
    S_DEC = 4'b0001,
    S_OP1 = 4'b0010,
    S_OP2 = 4'b0011,
    S_TBL = 4'b0100,
    S_VHI = 4'b0101,
    S_VLO = 4'b0110,
    S_XCH = 4'b0111,
    S_PUSH = 4'b1000,
    S_POP = 4'b1001,
    S_POP2 = 4'b1010
  } state_e;

  // Instruction length in bytes, used to step over skipped instructions.
  function automatic logic [14:0] op_len(input logic [7:0] o);
    if (o[7:4] == OP_PAGE_JUMP_HI || (o >= OP_ADD && o <= OP_IF_EQ) || o == OP_LDX_IMM || o == OP_LDB_IMM) begin
      return 15'h0002;
    end else if (o == OP_LONG_JUMP || o == OP_CALL) begin
      return 15'h0003;
    end else begin
      return 15'h0001;
    end
  endfunction

  // Six-bit field f encodes distance f+1, giving -31 to +32.
  function automatic logic [14:0] rel_dist(input logic [7:0] o);
    return {{9{o[5]}}, o[5:0]} + 15'h0001;
  endfunction
endpackage
`default_nettype wire

// ===== src/alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface alu_if;
  logic [7:0] fn;
  logic [7:0] a;
  logic [7:0] m;
  logic cin;
  logic [7:0] res;
  logic cout;
  modport core (output fn, output a, output m, output cin, input res, input cout);
  modport unit (input fn, input a, input m, input cin, output res, output cout);
endinterface
`default_nettype wire

// ===== src/acc_alu.sv
`timescale 1ns/10ps
`default_nettype none
module acc_alu
  import ctl_pkg::*;
(
  alu_if.unit bus
);
  logic [8:0] sum;
  logic [7:0] mop;
  logic ci;

  always_comb begin
    mop = bus.m;
    ci = 1'b0;
    bus.res = bus.a;
    bus.cout = bus.cin;
    case (bus.fn)
      OP_ADD_C: begin
        ci = bus.cin;
      end
      OP_SUB: begin
        mop = ~bus.m;
        ci = 1'b1;
      end
      OP_SUB_C: begin
        mop = ~bus.m;
        ci = bus.cin;
      end
      default: begin
        ci = 1'b0;
      end
    endcase
    sum = {1'b0, bus.a} + {1'b0, mop} + {8'h00, ci};
    case (bus.fn)
      OP_ADD, OP_ADD_C, OP_SUB, OP_SUB_C: begin
        bus.res = sum[7:0];
        bus.cout = sum[8];
      end
      OP_ROT_RIGHT: begin
        bus.res = {bus.cin, bus.a[7:1]};
        bus.cout = bus.a[0];
      end
      OP_ROT_LEFT: begin
        bus.res = {bus.a[6:0], bus.cin};
        bus.cout = bus.a[7];
      end
      OP_SWAP_NIB: begin
        bus.res = {bus.a[3:0], bus.a[7:4]};
      end
      default: begin
        bus.res = bus.a;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== src/flow_core.sv
`timescale 1ns/10ps
`default_nettype none
module flow_core
  import ctl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] pm_data,
  input wire logic [7:0] dm_rdata,
  input wire logic [3:0] irq_id,
  output logic [14:0] pm_addr,
  output logic [7:0] dm_addr,
  output logic dm_wr,
  output logic [7:0] dm_wdata,
  output logic [14:0] pc,
  output logic [7:0] acc,
  output logic carry,
  output logic [7:0] b_ptr,
  output logic [7:0] x_ptr,
  output logic [7:0] sp
);
  state_e state;
  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  logic skip;
  logic [7:0] cur;
  logic [14:0] pc_ret;

  alu_if alu();

  acc_alu u_alu (
    .bus(alu)
  );

  // Opcode in flight: fresh from memory while decoding, latched afterwards.
  assign cur = (state == S_DEC) ? pm_data : op;
  assign alu.fn = cur;
  assign alu.a = acc;
  assign alu.m = pm_data;
  assign alu.cin = carry;
  assign pc_ret = pc + 15'h0003;

  // ****************************************
  // Program flow
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_FETCH;
      pc <= PC_RESET;
      op <= OP_NOP;
      b1 <= 8'h00;
      b2 <= 8'h00;
      skip <= 1'b0;
      sp <= SP_RESET;
      pm_addr <= PC_RESET;
      dm_addr <= 8'h00;
      dm_wr <= 1'b0;
      dm_wdata <= 8'h00;
    end else if (ce) begin
      dm_wr <= 1'b0;
      case (state)
        S_FETCH: begin
          pm_addr <= pc;
          state <= S_DEC;
        end
        S_DEC: begin
          op <= pm_data;
          state <= S_FETCH;
          if (skip) begin
            skip <= 1'b0;
            pc <= pc + op_len(pm_data);
          end else if (pm_data[7:6] == OP_REL_TOP) begin
            pc <= pc + rel_dist(pm_data);
          end else if (op_len(pm_data) != 15'h0001) begin
            pm_addr <= pc + 15'h0001;
            state <= S_OP1;
          end else begin
            case (pm_data)
              OP_RETURN, OP_RETURN_SKIP, OP_INT_RETURN: begin
                sp <= sp + 8'h01;
                dm_addr <= sp + 8'h01;
                state <= S_POP;
              end
              OP_TABLE_READ: begin
                pm_addr <= {pc[14:8], acc};
                pc <= pc + 15'h0001;
                state <= S_TBL;
              end
              OP_INDIRECT_JUMP: begin
                pm_addr <= {pc[14:8], acc};
                state <= S_TBL;
              end
              OP_VECTOR_SEL: begin
                pm_addr <= VEC_BASE + {10'h000, irq_id, 1'b0};
                state <= S_VHI;
              end
              OP_XCH_BINC, OP_XCH_BDEC: begin
                dm_addr <= b_ptr;
                pc <= pc + 15'h0001;
                state <= S_XCH;
              end
              OP_XCH_XINC, OP_XCH_XDEC: begin
                dm_addr <= x_ptr;
                pc <= pc + 15'h0001;
                state <= S_XCH;
              end
              OP_IF_C: begin
                skip <= !carry;
                pc <= pc + 15'h0001;
              end
              OP_IF_NC: begin
                skip <= carry;
                pc <= pc + 15'h0001;
              end
              default: begin
                pc <= pc + 15'h0001;
              end
            endcase
          end
        end
        S_OP1: begin
          b1 <= pm_data;
          state <= S_FETCH;
          if (op_len(op) == 15'h0003) begin
            pm_addr <= pc + 15'h0002;
            state <= S_OP2;
          end else if (op[7:4] == OP_PAGE_JUMP_HI) begin
            pc <= {pc[14:12], op[3:0], pm_data};
          end else begin
            if (op == OP_IF_EQ) begin
              skip <= (acc != pm_data);
            end
            pc <= pc + 15'h0002;
          end
        end
        S_OP2: begin
          b2 <= pm_data;
          state <= S_FETCH;
          if (op == OP_CALL) begin
            dm_addr <= sp;
            dm_wdata <= pc_ret[7:0];
            dm_wr <= 1'b1;
            sp <= sp - 8'h01;
            pc <= pc_ret;
            state <= S_PUSH;
          end else begin
            pc <= {b1[6:0], pm_data};
          end
        end
        S_PUSH: begin
          dm_addr <= sp;
          dm_wdata <= {1'b0, pc[14:8]};
          dm_wr <= 1'b1;
          sp <= sp - 8'h01;
          pc <= {b1[6:0], b2};
          state <= S_FETCH;
        end
        S_POP: begin
          b1 <= dm_rdata;
          sp <= sp + 8'h01;
          dm_addr <= sp + 8'h01;
          state <= S_POP2;
        end
        S_POP2: begin
          pc <= {b1[6:0], dm_rdata};
          skip <= (op == OP_RETURN_SKIP);
          state <= S_FETCH;
        end
        S_TBL: begin
          if (op == OP_INDIRECT_JUMP) begin
            pc <= {pc[14:8], pm_data};
          end
          state <= S_FETCH;
        end
        S_VHI: begin
          b1 <= pm_data;
          pm_addr <= pm_addr + 15'h0001;
          state <= S_VLO;
        end
        S_VLO: begin
          pc <= {b1[6:0], pm_data};
          state <= S_FETCH;
        end
        S_XCH: begin
          dm_wdata <= acc;
          dm_wr <= 1'b1;
          state <= S_FETCH;
        end
        default: begin
          state <= S_FETCH;
        end
      endcase
    end
  end

  // ****************************************
  // Operand registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= 8'h00;
      carry <= 1'b0;
      b_ptr <= 8'h00;
      x_ptr <= 8'h00;
    end else if (ce) begin
      if (state == S_DEC && !skip) begin
        if (pm_data[7:4] == OP_LDB_SHORT_HI) begin
          b_ptr <= {NIB_ZERO, pm_data[3:0]};
        end else if (pm_data == OP_ROT_RIGHT || pm_data == OP_ROT_LEFT || pm_data == OP_SWAP_NIB) begin
          acc <= alu.res;
          carry <= alu.cout;
        end
      end
      if (state == S_OP1) begin
        case (op)
          OP_ADD, OP_ADD_C, OP_SUB, OP_SUB_C: begin
            acc <= alu.res;
            carry <= alu.cout;
          end
          OP_LDA_IMM: begin
            acc <= pm_data;
          end
          OP_LDX_IMM: begin
            x_ptr <= pm_data;
          end
          OP_LDB_IMM: begin
            b_ptr <= pm_data;
          end
          default: begin
            acc <= acc;
          end
        endcase
      end
      if (state == S_TBL && op == OP_TABLE_READ) begin
        acc <= pm_data;
      end
      if (state == S_XCH) begin
        acc <= dm_rdata;
        case (op)
          OP_XCH_BINC: b_ptr <= b_ptr + 8'h01;
          OP_XCH_BDEC: b_ptr <= b_ptr - 8'h01;
          OP_XCH_XINC: x_ptr <= x_ptr + 8'h01;
          default: x_ptr <= x_ptr - 8'h01;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // A stalled clock enable holds every register, so each antecedent includes ce.
  property p_short_b;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_DEC && !skip && pm_data[7:4] == OP_LDB_SHORT_HI) |=> b_ptr == {4'h0, $past(pm_data[3:0])};
  endproperty
  a_short_b: assert property (p_short_b) else $error("short pointer load wrong");

  property p_rel;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_DEC && !skip && pm_data[7:6] == OP_REL_TOP) |=> pc == $past(pc) + rel_dist($past(pm_data));
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");

  property p_page;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_OP1 && op[7:4] == OP_PAGE_JUMP_HI) |=> pc == {$past(pc[14:12]), $past(op[3:0]), $past(pm_data)};
  endproperty
  a_page: assert property (p_page) else $error("page jump wrong");

  property p_table;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_DEC && !skip && pm_data == OP_TABLE_READ) |=> (pm_addr == {$past(pc[14:8]), $past(acc)})
      ##1 (!$past(ce) || acc == $past(pm_data)) ##0 pc == $past(pc, 2) + 15'h0001;
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");

  property p_xch;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_XCH && op == OP_XCH_BINC) |=> b_ptr == $past(b_ptr) + 8'h01 && dm_wr && dm_addr == $past(b_ptr);
  endproperty
  a_xch: assert property (p_xch) else $error("pointer exchange wrong");

  property p_skip;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_DEC && skip) |=> pc == $past(pc) + op_len($past(pm_data)) && $stable(acc) && $stable(b_ptr)
      && state == S_FETCH && !skip;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction had effect");

  property p_ifc;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_DEC && !skip && pm_data == OP_IF_C) |=> skip == !$past(carry);
  endproperty
  a_ifc: assert property (p_ifc) else $error("carry test skip wrong");

  property p_ret;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_POP2) |=> pc == {$past(b1[6:0]), $past(dm_rdata)} && sp == $past(sp);
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");

  property p_long;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_OP2 && op == OP_LONG_JUMP) |=> pc == {$past(b1[6:0]), $past(pm_data)};
  endproperty
  a_long: assert property (p_long) else $error("long jump wrong");

  property p_ind;
    @(posedge clk) disable iff (!resetn)
    (ce && state == S_TBL && op == OP_INDIRECT_JUMP) |=> pc == {$past(pc[14:8]), $past(pm_data)};
  endproperty
  a_ind: assert property (p_ind) else $error("indirect jump wrong");
endmodule
`default_nettype wire

// ===== verif/prog_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Program and data memory model
// ****************************************
module prog_mem (
  input wire logic clk,
  input wire logic [14:0] pm_addr,
  output logic [7:0] pm_data,
  input wire logic [7:0] dm_addr,
  input wire logic dm_wr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata
);
  logic [7:0] rom [0:32767];
  logic [7:0] ram [0:255];
  // Both reads are combinational, so the core sees data in the cycle after it moves the address.
  assign pm_data = rom[pm_addr];
  assign dm_rdata = ram[dm_addr];
  // A plain always block, because the bench also preloads this array.
  always @(posedge clk) begin
    if (dm_wr) begin
      ram[dm_addr] <= dm_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ctl_pkg::*;
;
  logic clk;
  logic resetn;
  logic ce;
  logic [3:0] irq_id;
  logic [14:0] pm_addr, pc;
  logic [7:0] pm_data, dm_addr, dm_wdata, dm_rdata, acc, b_ptr, x_ptr, sp;
  logic dm_wr, carry;
  int failures = 0;
  int check_count = 0;
  int seed = 81;
  logic [7:0] ra, rm, rop;
  logic [8:0] ex;

  flow_core flow_core_i (.clk(clk), .resetn(resetn), .ce(ce), .pm_data(pm_data), .dm_rdata(dm_rdata),
    .irq_id(irq_id), .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .pc(pc),
    .acc(acc), .carry(carry), .b_ptr(b_ptr), .x_ptr(x_ptr), .sp(sp));
  prog_mem prog_mem_i (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic prog(input logic [14:0] a, input logic [7:0] q[$]);
    foreach (q[i]) begin
      prog_mem_i.rom[a + 15'(i)] = q[i];
    end
  endtask

  // Unused program space reads as no-op, so a stray fetch cannot wander into old programs.
  task automatic restart();
    @(negedge clk);
    resetn = 1'b0;
    ce = 1'b1;
    for (int i = 0; i < 32768; i++) begin
      prog_mem_i.rom[i] = OP_NOP;
    end
    for (int i = 0; i < 256; i++) begin
      prog_mem_i.ram[i] = 8'h00;
    end
    repeat (16) @(negedge clk);
  endtask

  // There is no completion flag; every program ends in a jump to itself, so a long fixed run is safe.
  task automatic run();
    resetn = 1'b1;
    repeat (150) begin
      @(negedge clk);
      ce = ($random(seed) & 32'h3) != 0;
    end
    ce = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  function automatic logic [8:0] expect_alu(input logic [7:0] a, input logic [7:0] m, input logic [7:0] op);
    logic [7:0] r;
    logic c;
    r = {1'b0, a[7:1]};
    c = a[0];
    case (op)
      OP_ADD: return {1'b0, r} + {1'b0, m};
      OP_ADD_C: return {1'b0, r} + {1'b0, m} + 9'(c);
      OP_SUB: return {1'b0, r} + {1'b0, ~m} + 9'h001;
      default: return {1'b0, r} + {1'b0, ~m} + 9'(c);
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    resetn = 1'b0;
    ce = 1'b0;
    irq_id = 4'h0;
    restart();
    prog(15'h0000, '{OP_LDB_IMM, 8'h12, 8'h47, OP_LDA_IMM, 8'h03, OP_XCH_BINC, OP_LDX_IMM, 8'h20, OP_XCH_XDEC,
      OP_XCH_XINC, OP_XCH_BDEC, 8'h3F});
    prog_mem_i.ram[7] = 8'h62;
    prog_mem_i.ram[8] = 8'hA7;
    prog_mem_i.ram[32] = 8'h5C;
    run();
    check(16'(acc), 16'h00A7);
    check(16'(b_ptr), 16'h0007);
    check(16'(x_ptr), 16'h0020);
    check(16'(prog_mem_i.ram[7]), 16'h0003);
    check(16'(prog_mem_i.ram[32]), 16'h0062);
    check(16'(prog_mem_i.ram[31]), 16'h005C);
    check(16'(prog_mem_i.ram[8]), 16'h0000);
    restart();
    prog(15'h0000, '{OP_LONG_JUMP, 8'h04, 8'h35});
    prog(15'h0435, '{OP_LDA_IMM, 8'h1F, OP_TABLE_READ, 8'h3F});
    prog_mem_i.rom[15'h041F] = 8'h25;
    run();
    check(16'(acc), 16'h0025);
    check(16'(pc), 16'h0438);
    restart();
    prog(15'h0000, '{OP_LONG_JUMP, 8'h01, 8'hC2});
    prog(15'h01C2, '{OP_LDA_IMM, 8'h26, OP_INDIRECT_JUMP});
    prog_mem_i.rom[15'h0126] = 8'h32;
    prog_mem_i.rom[15'h0132] = 8'h3F;
    run();
    check(16'(pc), 16'h0132);
    restart();
    prog(15'h0000, '{OP_LONG_JUMP, 8'h02, 8'h05});
    prog_mem_i.rom[15'h0205] = 8'h09;
    prog_mem_i.rom[15'h020F] = 8'h20;
    prog_mem_i.rom[15'h01F0] = 8'h1F;
    prog_mem_i.rom[15'h0210] = 8'h3F;
    run();
    check(16'(pc), 16'h0210);
    restart();
    prog(15'h0000, '{OP_LONG_JUMP, 8'hBC, 8'h77});
    prog(15'h3C77, '{8'h51, 8'h25});
    prog_mem_i.rom[15'h3125] = 8'h3F;
    run();
    check(16'(pc), 16'h3125);
    for (int k = 0; k < 2; k++) begin
      restart();
      irq_id = (k == 0) ? 4'h0 : 4'hF;
      prog(15'h0000, '{OP_VECTOR_SEL});
      prog(VEC_BASE + 15'(2 * irq_id), '{8'h12, 8'h34 + 8'(k)});
      prog_mem_i.rom[15'h1234 + 15'(k)] = 8'h3F;
      run();
      check(16'(pc), 16'h1234 + 16'(k));
    end
    restart();
    prog(15'h0000, '{OP_CALL, 8'h03, 8'h00, OP_LDA_IMM, 8'h11, OP_CALL, 8'h04, 8'h00, OP_LDA_IMM, 8'h22,
      OP_CALL, 8'h05, 8'h00, 8'h3F});
    prog_mem_i.rom[15'h0300] = OP_RETURN;
    prog_mem_i.rom[15'h0400] = OP_RETURN_SKIP;
    prog_mem_i.rom[15'h0500] = OP_INT_RETURN;
    run();
    check(16'(acc), 16'h0011);
    check(16'(pc), 16'h000D);
    check(16'(sp), 16'(SP_RESET));
    check(16'(prog_mem_i.ram[SP_RESET]), 16'h000D);
    restart();
    prog(15'h0000, '{OP_LDA_IMM, 8'hF0, OP_SUB, 8'h20, OP_IF_C, OP_LDA_IMM, 8'h5A, OP_IF_NC, OP_LDA_IMM,
      8'h66, OP_IF_EQ, 8'h5A, OP_SWAP_NIB, OP_IF_EQ, 8'h00, OP_SWAP_NIB, OP_ROT_LEFT, 8'h3F});
    run();
    check(16'(acc), 16'h004B);
    check(16'(carry), 16'h0001);
    for (int n = 0; n < 20; n++) begin
      restart();
      ra = 8'($random(seed));
      rm = (n == 0) ? 8'hFF : 8'($random(seed));
      rop = OP_ADD + 8'($random(seed) & 32'h3);
      prog(15'h0000, '{OP_LDA_IMM, ra, OP_ROT_RIGHT, rop, rm, 8'h3F});
      ex = expect_alu(ra, rm, rop);
      run();
      check(16'(acc), 16'(ex[7:0]));
      check(16'(carry), 16'(ex[8]));
    end
    stop_test();
  end
endmodule
`default_nettype wire
